// *** verilog/sspp_top.sv ***
// stepper pulse path of one axis with apb registers
`timescale 1ns/1ns
module sspp_top
  import sspp_pkg::*;
(
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        PROF_STEP_IN,
  input  wire logic        PROF_DIR_IN,
  input  wire logic        PROF_DONE_IN,
  input  wire logic        ENC_A_IN,
  input  wire logic        ENC_B_IN,
  output logic             STEP_OUT,
  output logic             DIR_OUT,
  output logic             AFTER_PROFILE_OUT,
  output logic             MOTION_COMPLETE_OUT,
  output logic             AXIS_STOP_OUT,
  output logic             ERROR_EVENT_OUT
);
  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_PULSE, S_GAP} sspp_st_type;

  function automatic logic [3:0] klim(input logic [3:0] k);
    return (k < K_MIN) ? K_MIN : ((k > K_MAX) ? K_MAX : k);
  endfunction

  function automatic logic signed [47:0] fstep(input logic signed [47:0] x,
                                               input logic signed [47:0] y,
                                               input logic [3:0] k);
    return y + ((x - y) >>> k);
  endfunction

  // ==========================================
  // apb slave and settings
  logic [1:0]  mtype, next_mtype;
  logic [3:0]  ks, next_ks, it, next_it;
  logic [1:0]  step_position_maintenance, next_spm;
  logic        stop_en, next_stop_en, halt, next_halt, evt, next_evt;
  logic [15:0] ya, next_ya, yb, next_yb, yc, next_yc;
  logic [31:0] prdata, next_prdata;
  logic        pready, next_pready, pslverr, next_pslverr;
  logic        wr, def_pos, def_enc, hit, viol, clr_ok;
  logic signed [31:0] ref_pos, step_cnt, enc_pos, err;
  logic        err_vld;
  logic [31:0] err_abs;
  logic [17:0] lim;
  sspp_st_type st;

  always_comb begin
    wr      = PSEL_IN & PENABLE_IN & pready & PWRITE_IN;
    def_pos = wr & (PADDR_IN == A_REF || PADDR_IN == A_STEPS);
    def_enc = wr & (PADDR_IN == A_ENC);
    err_abs = err[31] ? 32'(-err) : 32'(err);
    lim     = 18'(ya) * 18'(ERR_FULL_STEPS);
    viol    = err_vld & (step_position_maintenance == SPM_ON) & (err_abs > 32'(lim));
    clr_ok  = err_vld & (step_position_maintenance == SPM_ERR) & !halt & (err_abs < 32'(lim));
    hit = 1'b1;
    next_prdata = 32'h0;
    case (PADDR_IN)
      A_MTYPE: next_prdata = 32'(mtype);
      A_KS:    next_prdata = 32'(ks);
      A_IT:    next_prdata = 32'(it);
      A_REF:   next_prdata = ref_pos;
      A_STEPS: next_prdata = step_cnt;
      A_ENC:   next_prdata = enc_pos;
      A_ERR:   next_prdata = err;
      A_SPM:   next_prdata = 32'({stop_en, 2'h0, step_position_maintenance});
      A_YA:    next_prdata = 32'(ya);
      A_YB:    next_prdata = 32'(yb);
      A_YC:    next_prdata = 32'(yc);
      A_STAT:  next_prdata = 32'({AXIS_STOP_OUT, MOTION_COMPLETE_OUT, AFTER_PROFILE_OUT});
      default: hit = 1'b0;
    endcase
    next_pready  = PSEL_IN & !PENABLE_IN;
    next_pslverr = PSEL_IN & !PENABLE_IN & !hit;
    next_mtype = mtype;
    next_ks = ks;
    next_it = it;
    next_stop_en = stop_en;
    next_ya = ya;
    next_yb = yb;
    next_yc = yc;
    next_spm = step_position_maintenance;
    next_halt = halt;
    if (wr) begin
      case (PADDR_IN)
        A_MTYPE: next_mtype = PWDATA_IN[1:0];
        A_KS:    next_ks = klim(PWDATA_IN[3:0]);
        A_IT:    next_it = (PWDATA_IN[3:0] == 4'h0) ? 4'h0 : klim(PWDATA_IN[3:0]);
        A_YA:    next_ya = PWDATA_IN[15:0];
        A_YB:    next_yb = PWDATA_IN[15:0];
        A_YC:    next_yc = PWDATA_IN[15:0];
        A_SPM: begin
          next_spm = PWDATA_IN[1:0];
          next_stop_en = PWDATA_IN[SPM_STOP];
          next_halt = 1'b0;
        end
        default: ;
      endcase
    end
    if (clr_ok) next_spm = SPM_ON;
    // a violation wins over a same-cycle software write
    if (viol) begin
      next_spm = SPM_ERR;
      if (stop_en) next_halt = 1'b1;
    end
    next_evt = viol;
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      mtype <= MT_RST;
      ks <= KS_RST;
      it <= IT_RST;
      ya <= YA_RST;
      yb <= YB_RST;
      yc <= YC_RST;
      step_position_maintenance <= SPM_OFF;
      stop_en <= 1'b0;
      halt <= 1'b0;
      evt <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      mtype <= next_mtype;
      ks <= next_ks;
      it <= next_it;
      ya <= next_ya;
      yb <= next_yb;
      yc <= next_yc;
      step_position_maintenance <= next_spm;
      stop_en <= next_stop_en;
      halt <= next_halt;
      evt <= next_evt;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  assign PRDATA_OUT      = prdata;
  assign PREADY_OUT      = pready;
  assign PSLVERR_OUT     = pslverr;
  assign AXIS_STOP_OUT   = halt;
  assign ERROR_EVENT_OUT = evt;

  // ==========================================
  // reference counter and smoothing filters
  logic [4:0] tdiv, next_tdiv;
  logic       tick;
  logic signed [31:0] next_ref;
  logic signed [47:0] s1, next_s1, s2, next_s2, x0;
  logic signed [31:0] target;

  always_comb begin
    tick = (tdiv == 5'(SAMPLE_CYC - 1));
    next_tdiv = tick ? 5'h0 : tdiv + 5'h1;
    next_ref = ref_pos;
    if (PROF_STEP_IN) next_ref = PROF_DIR_IN ? ref_pos - 1 : ref_pos + 1;
    x0 = {ref_pos, 16'h0};
    next_s1 = s1;
    next_s2 = s2;
    if (tick) begin
      next_s1 = (it == 4'h0) ? x0 : fstep(x0, s1, klim(it));
      next_s2 = fstep(s1, s2, klim(ks));
    end
    if (def_pos) begin
      next_ref = PWDATA_IN;
      next_s1 = {PWDATA_IN, 16'h0};
      next_s2 = {PWDATA_IN, 16'h0};
    end
    target = 32'((s2 + 48'sh8000) >>> FRAC);
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      tdiv <= 5'h0;
      ref_pos <= 32'sh0;
      s1 <= 48'sh0;
      s2 <= 48'sh0;
    end else begin
      tdiv <= next_tdiv;
      ref_pos <= next_ref;
      s1 <= next_s1;
      s2 <= next_s2;
    end
  end

  // ==========================================
  // step generator, fed only by the filter output
  sspp_st_type next_st;
  logic [15:0] tmr, next_tmr;
  logic signed [31:0] next_step;
  logic        fwd, next_fwd, pon, next_pon, step_pin, next_step_pin, dir_pin, next_dir_pin;
  logic        after, next_after, mdone, next_mdone;

  always_comb begin
    next_st = st;
    next_tmr = (tmr != 16'h0) ? tmr - 16'h1 : 16'h0;
    next_step = step_cnt;
    next_fwd = fwd;
    next_pon = pon;
    case (st)
      // a stop raised in this very cycle already blocks a new pulse
      S_IDLE: if (!halt && !next_halt && target != step_cnt) begin
        next_fwd = target > step_cnt;
        next_tmr = 16'(DIR_CYC - 1);
        next_st = S_SETUP;
      end
      S_SETUP: if (tmr == 16'h0) begin
        next_pon = 1'b1;
        next_tmr = 16'(STEP_W_CYC - 1);
        next_st = S_PULSE;
      end
      S_PULSE: if (tmr == 16'h0) begin
        next_pon = 1'b0;
        next_step = fwd ? step_cnt + 1 : step_cnt - 1;
        next_tmr = 16'(STEP_GAP_CYC - 1);
        next_st = S_GAP;
      end
      S_GAP: if (tmr == 16'h0) next_st = S_IDLE;
      default: next_st = S_IDLE;
    endcase
    if (def_pos) next_step = PWDATA_IN;
    next_step_pin = next_pon ~^ next_mtype[MT_HIGH];
    next_dir_pin = next_fwd ^ next_mtype[MT_REV];
    next_after = PROF_DONE_IN;
    next_mdone = PROF_DONE_IN & (st == S_IDLE) & (step_cnt == ref_pos);
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      st <= S_IDLE;
      tmr <= 16'h0;
      step_cnt <= 32'sh0;
      fwd <= 1'b1;
      pon <= 1'b0;
      step_pin <= 1'b1;
      dir_pin <= 1'b1;
      after <= 1'b0;
      mdone <= 1'b0;
    end else begin
      st <= next_st;
      tmr <= next_tmr;
      step_cnt <= next_step;
      fwd <= next_fwd;
      pon <= next_pon;
      step_pin <= next_step_pin;
      dir_pin <= next_dir_pin;
      after <= next_after;
      mdone <= next_mdone;
    end
  end

  assign STEP_OUT            = step_pin;
  assign DIR_OUT             = dir_pin;
  assign AFTER_PROFILE_OUT   = after;
  assign MOTION_COMPLETE_OUT = mdone;

  // ==========================================
  // main encoder counter
  logic [1:0] a_sy, next_a_sy, b_sy, next_b_sy;
  logic       a_q, b_q;
  logic signed [31:0] next_enc;

  always_comb begin
    next_a_sy = {a_sy[0], ENC_A_IN};
    next_b_sy = {b_sy[0], ENC_B_IN};
    next_enc = enc_pos;
    if (a_sy[1] ^ a_q ^ b_sy[1] ^ b_q) next_enc = (a_sy[1] ^ b_q) ? enc_pos + 1 : enc_pos - 1;
    if (def_enc) next_enc = PWDATA_IN;
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      a_sy <= 2'h0;
      b_sy <= 2'h0;
      a_q <= 1'b0;
      b_q <= 1'b0;
      enc_pos <= 32'sh0;
    end else begin
      a_sy <= next_a_sy;
      b_sy <= next_b_sy;
      a_q <= a_sy[1];
      b_q <= b_sy[1];
      enc_pos <= next_enc;
    end
  end

  // ==========================================
  // maintenance error: serial divide by yc, 64 steps per result
  logic [6:0]  dcnt, next_dcnt;
  logic [63:0] dq, next_dq;
  logic [16:0] rem, next_rem, rsh;
  logic        neg, next_neg, next_vld;
  logic signed [63:0] prod;
  logic signed [31:0] next_err, q;

  always_comb begin
    prod = $signed(enc_pos) * $signed({1'b0, ya}) * $signed({1'b0, yb});
    next_dcnt = dcnt - 7'h1;
    next_dq = dq;
    next_rem = rem;
    next_neg = neg;
    next_err = err;
    next_vld = 1'b0;
    rsh = {rem[15:0], dq[63]};
    q = 32'sh0;
    if (dcnt == 7'h0) begin
      next_neg = prod[63];
      next_dq = prod[63] ? 64'(-prod) : 64'(prod);
      next_rem = 17'h0;
      next_dcnt = 7'h40;
    end else begin
      next_rem = (rsh >= {1'b0, yc}) ? rsh - {1'b0, yc} : rsh;
      next_dq = {dq[62:0], rsh >= {1'b0, yc}};
      if (dcnt == 7'h1) begin
        q = neg ? 32'(-next_dq) : 32'(next_dq);
        next_err = step_cnt - q;
        next_vld = 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      dcnt <= 7'h0;
      dq <= 64'h0;
      rem <= 17'h0;
      neg <= 1'b0;
      err <= 32'sh0;
      err_vld <= 1'b0;
    end else begin
      dcnt <= next_dcnt;
      dq <= next_dq;
      rem <= next_rem;
      neg <= next_neg;
      err <= next_err;
      err_vld <= next_vld;
    end
  end

  // ==========================================
  // checks
  a_step_count: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (st == S_PULSE && tmr == 16'h0 && !def_pos) |=>
      step_cnt == $past(step_cnt) + ($past(fwd) ? 32'sh1 : -32'sh1))
    else $error("step count not moved by one");
  a_dir_before: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (st == S_SETUP && tmr == 16'h0 && $stable(mtype)) |=> $stable(DIR_OUT))
    else $error("direction changed with pulse");
  a_define_pos: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    def_pos |=> (ref_pos == $past(PWDATA_IN)) && (step_cnt == $past(PWDATA_IN)))
    else $error("define position missed a counter");
  a_define_enc: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    def_enc |=> enc_pos == $past(PWDATA_IN))
    else $error("encoder define lost");
  a_filter_lag: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (tick && !def_pos && s1 > s2 + 48'sh1) |=> s2 < $past(s1))
    else $error("step smoothing bypassed");
  a_spm_flag: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    viol |=> (step_position_maintenance == SPM_ERR) && ERROR_EVENT_OUT ##1 !ERROR_EVENT_OUT)
    else $error("violation not flagged");
  a_axis_stop: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (viol && stop_en) |=> AXIS_STOP_OUT && (st != S_SETUP || $past(st) == S_SETUP))
    else $error("axis not stopped");
  a_halt_idle: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (AXIS_STOP_OUT && st == S_IDLE) |=> st == S_IDLE)
    else $error("pulse started while stopped");
  a_rest_level: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (st == S_GAP && $stable(mtype)) |=> STEP_OUT == !mtype[MT_HIGH])
    else $error("step output not at rest level");
  a_motion_done: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    MOTION_COMPLETE_OUT |-> $past(step_cnt == ref_pos))
    else $error("motion complete with steps pending");
endmodule // sspp_top

// *** verilog/sspp_pkg.sv ***
// constants shared by the stepper pulse path
package sspp_pkg;
  // ==========================================
  // register byte addresses
  localparam logic [7:0] A_MTYPE = 8'h00;
  localparam logic [7:0] A_KS    = 8'h04;
  localparam logic [7:0] A_IT    = 8'h08;
  localparam logic [7:0] A_REF   = 8'h0c;
  localparam logic [7:0] A_STEPS = 8'h10;
  localparam logic [7:0] A_ENC   = 8'h14;
  localparam logic [7:0] A_ERR   = 8'h18;
  localparam logic [7:0] A_SPM   = 8'h1c;
  localparam logic [7:0] A_YA    = 8'h20;
  localparam logic [7:0] A_YB    = 8'h24;
  localparam logic [7:0] A_YC    = 8'h28;
  localparam logic [7:0] A_STAT  = 8'h2c;
  // ==========================================
  // field positions
  localparam int MT_HIGH  = 0;
  localparam int MT_REV   = 1;
  localparam int SPM_STOP = 4;
  localparam int ST_AFTER = 0;
  localparam int ST_DONE  = 1;
  localparam int ST_HALT  = 2;
  // ==========================================
  // reset values and codes
  localparam logic [1:0]  MT_RST  = 2'h0;
  localparam logic [3:0]  KS_RST  = 4'h1;
  localparam logic [3:0]  IT_RST  = 4'h0;
  localparam logic [15:0] YA_RST  = 16'h0001;
  localparam logic [15:0] YB_RST  = 16'h00c8;
  localparam logic [15:0] YC_RST  = 16'h0fa0;
  localparam logic [1:0]  SPM_OFF = 2'h0;
  localparam logic [1:0]  SPM_ON  = 2'h1;
  localparam logic [1:0]  SPM_ERR = 2'h2;
  localparam logic [1:0]  ERR_FULL_STEPS = 2'h3;
  // ==========================================
  // filter shape
  localparam int         FRAC  = 16;
  localparam logic [3:0] K_MIN = 4'h1;
  localparam logic [3:0] K_MAX = 4'hc;
  // ==========================================
  // timing
  localparam int CLK_NS       = 50;
  localparam int SAMPLE_NS    = 1000;
  localparam int DIR_SETUP_NS = 500;
  localparam int STEP_W_NS    = 1000;
  localparam int STEP_GAP_NS  = 1000;
  localparam int SAMPLE_CYC   = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int DIR_CYC      = (DIR_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_W_CYC   = (STEP_W_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_GAP_CYC = (STEP_GAP_NS + CLK_NS - 1) / CLK_NS;
endpackage

// *** test/sspp_partner.sv ***
// far-side model: step driver that counts pulses, and a quadrature encoder
`timescale 1ns/1ns
module sspp_partner (
  input  wire logic clk_in,
  input  wire logic step_in,
  input  wire logic dir_in,
  input  wire logic act_high_in,
  input  wire logic rev_in,
  output logic      enc_a_out,
  output logic      enc_b_out
);
  int         pos;
  logic       last_dir;
  logic       step_q;
  logic [1:0] phase;

  // ==========================================
  // step driver: one count per leading edge of the active level
  initial begin
    pos = 0;
    step_q = 1'b1;
    phase = 2'h0;
    last_dir = 1'b0;
  end

  always @(negedge clk_in) begin
    step_q <= step_in;
    if ((step_in === act_high_in) && (step_q !== act_high_in)) begin
      last_dir <= dir_in;
      pos <= ((dir_in ^ rev_in) === 1'b1) ? pos + 1 : pos - 1;
    end
  end

  // ==========================================
  // encoder on the main input, gray sequence, one quarter cycle and one count per step
  assign enc_a_out = phase[1];
  assign enc_b_out = phase[1] ^ phase[0];

  task automatic enc_move(input int cnt);
    for (int i = 0; i < ((cnt < 0) ? -cnt : cnt); i++) begin
      repeat (4) @(posedge clk_in);
      phase <= (cnt < 0) ? phase - 2'h1 : phase + 2'h1;
    end
  endtask
endmodule  // sspp_partner

// *** test/tb_stepper_pulse_path.sv ***
// self-checking bench of the stepper pulse path
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin \
  total_checks++; \
  if ((gt) !== (ex)) begin \
    err_total++; \
    $display("[FAIL] %s expected %0d seen %0d", nm, ex, gt); \
  end \
end
module tb_stepper_pulse_path;
  import sspp_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pstep, pdir, pdone;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  logic        pready, pslverr, se, enc_a, enc_b, step, dir;
  logic        after_p, mcomp, astop, evt;
  logic [1:0]  mt;
  int          err_total, total_checks, cyc, ev_cnt, ref_m, off, n, p0, c0, v;
  int          lat [2];
  logic [7:0]  ra [8];
  logic [31:0] rx [8];

  sspp_top i_sspp_top (
    .SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PROF_STEP_IN(pstep),
    .PROF_DIR_IN(pdir), .PROF_DONE_IN(pdone), .ENC_A_IN(enc_a), .ENC_B_IN(enc_b),
    .STEP_OUT(step), .DIR_OUT(dir), .AFTER_PROFILE_OUT(after_p),
    .MOTION_COMPLETE_OUT(mcomp), .AXIS_STOP_OUT(astop), .ERROR_EVENT_OUT(evt)
  );

  sspp_partner i_sspp_partner (
    .clk_in(clk), .step_in(step), .dir_in(dir), .act_high_in(mt[0]),
    .rev_in(mt[1]), .enc_a_out(enc_a), .enc_b_out(enc_b)
  );

  // ==========================================
  // clock, timeout, event monitor
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      final_report();
    end
  end

  always @(negedge clk) begin
    if (evt === 1'b1) ev_cnt++;
  end

  // ==========================================
  // tasks
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    if (k >= 100) err_total++;
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic move(input int cnt, input logic down);
    pdone <= 1'b0;
    for (int i = 0; i < cnt; i++) begin
      @(posedge clk);
      pstep <= 1'b1;
      pdir <= down;
      @(posedge clk);
      pstep <= 1'b0;
    end
    @(posedge clk);
    pdone <= 1'b1;
    ref_m = down ? ref_m - cnt : ref_m + cnt;
  endtask

  task automatic wait_mc();
    int k;
    k = 0;
    while (mcomp !== 1'b1 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 20000) err_total++;
  endtask

  task automatic define_pos(input int val);
    apb(1'b1, A_REF, val);
    off = i_sspp_partner.pos - val;
    ref_m = val;
  endtask

  // ==========================================
  // main sequence
  initial begin
    {rst_n, psel, penable, pwrite, pstep, pdir, pdone} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    mt = 2'h0;
    ra = '{A_MTYPE, A_KS, A_IT, A_REF, A_STEPS, A_YA, A_YB, A_YC};
    rx = '{32'(MT_RST), 32'(KS_RST), 32'(IT_RST), 32'h0, 32'h0,
           32'(YA_RST), 32'(YB_RST), 32'(YC_RST)};
    void'($urandom(32'h0e80));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK("step_idle", 1'b1, step)
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      `CHK("reset_val", rx[i], rv)
    end
    apb(1'b0, 8'h30, 32'h0);
    `CHK("unmapped_err", 1'b1, se)
    `CHK("unmapped_data", 32'h0, rv)
    apb(1'b1, A_KS, 32'h0);
    apb(1'b0, A_KS, 32'h0);
    `CHK("ks_min", 32'(K_MIN), rv)
    apb(1'b1, A_IT, 32'hf);
    apb(1'b0, A_IT, 32'h0);
    `CHK("it_max", 32'(K_MAX), rv)
    apb(1'b1, A_IT, 32'h0);
    $display("test reset and clamps done");

    for (int m = 0; m < 4; m++) begin
      mt = m[1:0];
      apb(1'b1, A_MTYPE, 32'(mt));
      for (int d = 0; d < 2; d++) begin
        move(1 + $urandom % 4, d[0]);
        @(posedge clk);
        @(negedge clk);
        `CHK("after_prof", 1'b1, after_p)
        `CHK("mc_early", 1'b0, mcomp)
        wait_mc();
        `CHK("step_rest", ~mt[0], step)
        apb(1'b0, A_REF, 32'h0);
        `CHK("ref_pos", ref_m, rv)
        apb(1'b0, A_STEPS, 32'h0);
        `CHK("step_cnt", ref_m, rv)
        `CHK("driver_pos", ref_m, i_sspp_partner.pos - off)
        `CHK("dir_sense", ~(mt[1] ^ d[0]), i_sspp_partner.last_dir)
      end
    end
    $display("test motor types done");

    for (int k = 0; k < 2; k++) begin
      apb(1'b1, A_KS, (k == 1) ? 32'h3 : 32'h1);
      apb(1'b1, A_IT, (k == 1) ? 32'h2 : 32'h0);
      p0 = i_sspp_partner.pos;
      c0 = cyc;
      move(2, 1'b0);
      while (i_sspp_partner.pos == p0 && cyc - c0 < 20000) @(negedge clk);
      lat[k] = cyc - c0;
      wait_mc();
      apb(1'b0, A_STEPS, 32'h0);
      `CHK("smooth_steps", ref_m, rv)
    end
    `CHK("smooth_delay", 1'b1, 1'(lat[1] > lat[0]))
    apb(1'b1, A_KS, 32'h1);
    apb(1'b1, A_IT, 32'h0);
    $display("test smoothing done");

    v = int'($urandom % 1000) - 500;
    p0 = i_sspp_partner.pos;
    apb(1'b1, A_STEPS, v);
    off = p0 - v;
    ref_m = v;
    apb(1'b0, A_REF, 32'h0);
    `CHK("define_ref", v, rv)
    apb(1'b0, A_STEPS, 32'h0);
    `CHK("define_steps", v, rv)
    `CHK("define_nostep", p0, i_sspp_partner.pos)
    define_pos(0);
    apb(1'b0, A_STEPS, 32'h0);
    `CHK("define_zero", 0, rv)
    $display("test define position done");

    apb(1'b1, A_ENC, 32'd100);
    p0 = i_sspp_partner.pos;
    i_sspp_partner.enc_move(8);
    repeat (10) @(posedge clk);
    apb(1'b0, A_ENC, 32'h0);
    v = int'(rv) - 100;
    `CHK("enc_count", 8, (v < 0) ? -v : v)
    `CHK("no_servo", p0, i_sspp_partner.pos)
    $display("test encoder done");

    apb(1'b1, A_ENC, 32'h0);
    define_pos(0);
    repeat (140) @(posedge clk);
    apb(1'b1, A_SPM, 32'h11);
    c0 = ev_cnt;
    move(10, 1'b0);
    for (int k = 0; k < 20000 && astop !== 1'b1; k++) @(negedge clk);
    repeat (200) @(posedge clk);
    `CHK("halted", 1'b1, astop)
    `CHK("event_once", 1, ev_cnt - c0)
    apb(1'b0, A_SPM, 32'h0);
    `CHK("spm_status", 32'(SPM_ERR), {30'h0, rv[1:0]})
    apb(1'b0, A_STEPS, 32'h0);
    v = int'(rv);
    `CHK("halt_steps", v, i_sspp_partner.pos - off)
    `CHK("halt_range", 1'b1, 1'(v > 3 && v < 10))
    apb(1'b1, A_ENC, 32'd40);
    repeat (140) @(posedge clk);
    apb(1'b0, A_ERR, 32'h0);
    `CHK("err_value", v - 2, int'(rv))
    apb(1'b1, A_SPM, 32'h0);
    @(negedge clk);
    `CHK("stop_clear", 1'b0, astop)
    wait_mc();
    apb(1'b1, A_ENC, 32'h0);
    define_pos(0);
    apb(1'b1, A_SPM, 32'h01);
    c0 = ev_cnt;
    move(6, 1'b0);
    wait_mc();
    repeat (70) @(posedge clk);
    `CHK("run_on", 6, i_sspp_partner.pos - off)
    `CHK("event_run", 1, ev_cnt - c0)
    apb(1'b0, A_ERR, 32'h0);
    `CHK("err_run", 6, int'(rv))
    apb(1'b0, A_STAT, 32'h0);
    `CHK("stat_flags", 3'h3, rv[2:0])
    $display("test maintenance done");
    final_report();
  end
endmodule  // tb_stepper_pulse_path
